// File: rtl/power_stage_fault_supervisor.sv
`timescale 1ns/1ns
`include "power_stage_fault_supervisor_cfg.svh"

// Behaviour
// (R1) short check only at power-up start-up
// (R2) short seen: all bridges hi-z, wait
// (R3) two steps: ground first, then supply
// (R4) check step length is a parameter
// (R5) fault low, reset ignored during check
// (R6) reset never restarts the short check
// (R7) check skipped in single-ended mode
// (R8) bootstrap undervoltage disables own bridge only
// (R9) warnings low above 100 and 125 C
// (R10) above 155 C latched shutdown, fault low
// (R11) thermal latch cleared only by reset
// (R12) two-level variant single 125 C warning
// (R13) supply undervoltage: hi-z, fault, auto-recover
// (R14) power-on clears overload state
// (R15) reset low forces all bridges hi-z
// (R16) reset low: weak pulldown unless single-ended
// (R17) reset low holds fault output high
// (R18) reset rise clears overload, restarts switching
// (R19) controller waits 4 ms before reset release; the model waits HOLD_CYC cycles after the fault goes low
// (R20) overcurrent drives ready low
// (R21) controller plays audio only when ready
// (R22) trim tied to regulator: external clock
// (R23) overload and thermal latch, others recover
// (R24) fault and warnings are open-drain low
// (R25) comparator inputs synchronised before use
module power_stage_fault_supervisor #(
  parameter int STEP_CYC = `SHORT_STEP_CYC,
  parameter bit THREE_LEVEL = 1'b1
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic rst_pin_n,
  input wire power_stage_fault_supervisor_pkg::out_cfg_t out_cfg,
  input wire logic supply_present,
  input wire logic [`HALF_BRIDGES-1:0] gate_drive_supply_low,
  input wire logic common_supply_low,
  input wire logic [`HALF_BRIDGES-1:0] bootstrap_low,
  input wire logic temp_over_100,
  input wire logic temp_over_125,
  input wire logic temp_over_155,
  input wire logic overload_guard,
  input wire logic overcurrent_guard,
  input wire logic short_to_gnd,
  input wire logic short_to_supply,
  input wire logic freq_trim_pin,
  output logic [`HALF_BRIDGES-1:0] bridge_enable,
  output logic weak_pulldown,
  output logic fault_shutdown_n_oe,
  output logic temp_warn_low_n_oe,
  output logic temp_warn_high_n_oe,
  output logic temp_warn_n_oe,
  output logic ready,
  output logic osc_sync_pins_oe,
  output logic osc_run
);
  localparam int NB = `HALF_BRIDGES;
  localparam int SW = NB * 2 + 11;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [SW-1:0] raw_in;
  logic [SW-1:0] syn;
  assign raw_in = {rst_pin_n, supply_present, gate_drive_supply_low, common_supply_low,
                   bootstrap_low, temp_over_100, temp_over_125, temp_over_155,
                   overload_guard, overcurrent_guard, short_to_gnd, short_to_supply,
                   freq_trim_pin};
  input_sync #(.WIDTH(SW)) u_sync ( // R25
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in(raw_in),
    .sync_out(syn)
  );
  logic s_rst_n, s_sup, s_cuv, s_t100, s_t125, s_t155, s_ol, s_oc, s_sg, s_ss, s_trim;
  logic [NB-1:0] s_guv, s_buv;
  assign {s_rst_n, s_sup, s_guv, s_cuv, s_buv, s_t100, s_t125, s_t155,
          s_ol, s_oc, s_sg, s_ss, s_trim} = syn;

  logic undervoltage_guard;
  assign undervoltage_guard = s_cuv | (|s_guv);

  // ----------------------------------------
  // start-up sequencer
  // ----------------------------------------
  power_stage_fault_supervisor_pkg::seq_state_t state, next_state;
  logic [31:0] step_cnt, next_step_cnt;
  logic check_done, next_check_done;
  logic thermal_trip, next_thermal_trip;
  logic ol_latch, next_ol_latch;
  logic rst_prev, next_rst_prev;
  logic in_check;
  logic se_mode;

  assign se_mode = (out_cfg == power_stage_fault_supervisor_pkg::single_ended_cfg);
  assign in_check = (state == power_stage_fault_supervisor_pkg::st_check_gnd) ||
                    (state == power_stage_fault_supervisor_pkg::st_check_supply);

  always_comb begin
    next_state = state;
    next_step_cnt = step_cnt;
    next_check_done = check_done;
    next_rst_prev = s_rst_n;
    case (state)
      power_stage_fault_supervisor_pkg::st_wait_supply: begin
        next_step_cnt = '0;
        if (s_sup && !undervoltage_guard) begin
          if (check_done || se_mode) begin // R6 R7
            next_state = power_stage_fault_supervisor_pkg::st_run;
            next_check_done = 1'b1;
          end else begin
            next_state = power_stage_fault_supervisor_pkg::st_check_gnd; // R1
          end
        end
      end
      power_stage_fault_supervisor_pkg::st_check_gnd: begin
        if (s_sg) begin
          next_step_cnt = '0; // R2
        end else if (step_cnt >= 32'(STEP_CYC - 1)) begin // R4
          next_step_cnt = '0;
          next_state = power_stage_fault_supervisor_pkg::st_check_supply; // R3
        end else begin
          next_step_cnt = step_cnt + 32'd1;
        end
      end
      power_stage_fault_supervisor_pkg::st_check_supply: begin
        if (s_ss) begin
          next_step_cnt = '0; // R2
        end else if (step_cnt >= 32'(STEP_CYC - 1)) begin
          next_step_cnt = '0;
          next_check_done = 1'b1;
          next_state = power_stage_fault_supervisor_pkg::st_run; // R3
        end else begin
          next_step_cnt = step_cnt + 32'd1;
        end
      end
      power_stage_fault_supervisor_pkg::st_run: begin
        if (!s_sup) begin
          next_state = power_stage_fault_supervisor_pkg::st_wait_supply;
        end
      end
      default: begin
        next_state = power_stage_fault_supervisor_pkg::st_wait_supply;
      end
    endcase
  end

  // ----------------------------------------
  // latched protections
  // ----------------------------------------
  always_comb begin
    next_thermal_trip = thermal_trip;
    next_ol_latch = ol_latch;
    if (!in_check && !s_rst_n) begin
      next_thermal_trip = 1'b0; // R11
    end
    if (!in_check && s_rst_n && !rst_prev) begin
      next_ol_latch = 1'b0; // R18
    end
    if (s_t155) begin
      next_thermal_trip = 1'b1; // R10 R23
    end
    if (s_ol && state == power_stage_fault_supervisor_pkg::st_run) begin
      next_ol_latch = 1'b1; // R23
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= power_stage_fault_supervisor_pkg::st_wait_supply;
      step_cnt <= '0;
      check_done <= 1'b0;
      thermal_trip <= 1'b0;
      ol_latch <= 1'b0; // R14
      rst_prev <= 1'b0;
    end else begin
      state <= next_state;
      step_cnt <= next_step_cnt;
      check_done <= next_check_done;
      thermal_trip <= next_thermal_trip;
      ol_latch <= next_ol_latch;
      rst_prev <= next_rst_prev;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic group_off;
  logic rst_active;
  logic [NB-1:0] next_bridge_enable;
  logic next_pulldown, next_fault_oe, next_ready;

  assign rst_active = !s_rst_n && !in_check;
  assign group_off = (state != power_stage_fault_supervisor_pkg::st_run) ||
                     thermal_trip || ol_latch || undervoltage_guard || rst_active; // R13 R15

  always_comb begin
    next_bridge_enable = group_off ? '0 : ~s_buv; // R8
    next_pulldown = rst_active && !se_mode; // R16
    if (rst_active) begin
      next_fault_oe = 1'b0; // R17
    end else begin
      next_fault_oe = in_check || thermal_trip || ol_latch || undervoltage_guard; // R5 R24
    end
    next_ready = !group_off && !s_oc; // R20
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bridge_enable <= '0;
      weak_pulldown <= 1'b0;
      fault_shutdown_n_oe <= 1'b0;
      temp_warn_low_n_oe <= 1'b0;
      temp_warn_high_n_oe <= 1'b0;
      temp_warn_n_oe <= 1'b0;
      ready <= 1'b0;
      osc_sync_pins_oe <= 1'b0;
      osc_run <= 1'b0;
    end else begin
      bridge_enable <= next_bridge_enable;
      weak_pulldown <= next_pulldown;
      fault_shutdown_n_oe <= next_fault_oe;
      temp_warn_low_n_oe <= THREE_LEVEL && (s_t100 || s_t125); // R9
      temp_warn_high_n_oe <= THREE_LEVEL && s_t125; // R9
      temp_warn_n_oe <= !THREE_LEVEL && s_t125; // R12
      ready <= next_ready;
      osc_sync_pins_oe <= !s_trim; // R22
      osc_run <= !s_trim; // R22
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence thermal_seen;
    s_t155;
  endsequence

  a_thermal_shutdown: assert property (@(posedge sys_clk) disable iff (!reset_n) // R10
    thermal_seen |=> ##1 (bridge_enable == '0))
    else $error("thermal trip did not disable bridges");
  a_thermal_holds: assert property (@(posedge sys_clk) disable iff (!reset_n) // R11
    (thermal_trip && s_rst_n) |=> thermal_trip)
    else $error("thermal latch cleared without reset");
  a_check_fault_low: assert property (@(posedge sys_clk) disable iff (!reset_n) // R5
    in_check |=> fault_shutdown_n_oe)
    else $error("fault not driven during short check");
  a_se_skip_check: assert property (@(posedge sys_clk) disable iff (!reset_n) // R7
    (state == power_stage_fault_supervisor_pkg::st_wait_supply && se_mode && !check_done)
    |=> !in_check)
    else $error("short check run in single-ended mode");
  a_reset_hiz: assert property (@(posedge sys_clk) disable iff (!reset_n) // R15
    rst_active |=> (bridge_enable == '0))
    else $error("bridges enabled during reset");
  a_reset_fault_high: assert property (@(posedge sys_clk) disable iff (!reset_n) // R17
    rst_active |=> !fault_shutdown_n_oe)
    else $error("fault driven while reset low");
  a_uv_fault: assert property (@(posedge sys_clk) disable iff (!reset_n) // R13
    (undervoltage_guard && !rst_active) |=> (fault_shutdown_n_oe && bridge_enable == '0))
    else $error("undervoltage not signalled");
  a_oc_not_ready: assert property (@(posedge sys_clk) disable iff (!reset_n) // R20
    s_oc |=> !ready)
    else $error("ready high during overcurrent");
  a_no_recheck: assert property (@(posedge sys_clk) disable iff (!reset_n) // R6
    check_done |=> !in_check)
    else $error("short check restarted");
  a_pulldown_mode: assert property (@(posedge sys_clk) disable iff (!reset_n) // R16
    (rst_active && se_mode) |=> !weak_pulldown)
    else $error("pulldown in single-ended mode");
endmodule : power_stage_fault_supervisor

// File: rtl/power_stage_fault_supervisor_cfg.svh
`ifndef POWER_STAGE_FAULT_SUPERVISOR_CFG_SVH
`define POWER_STAGE_FAULT_SUPERVISOR_CFG_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 125
`define SHORT_STEP_US 15000
`define SHORT_STEP_CYC (`SHORT_STEP_US * `CLK_MHZ)
`define HALF_BRIDGES 4

`endif

// File: rtl/power_stage_fault_supervisor_pkg.sv
package power_stage_fault_supervisor_pkg;
  typedef enum logic [1:0] {
    bridge_tied_cfg,
    parallel_bridge_cfg,
    single_ended_cfg,
    cfg_reserved
  } out_cfg_t;

  typedef enum logic [2:0] {
    st_wait_supply,
    st_check_gnd,
    st_check_supply,
    st_run
  } seq_state_t;
endpackage : power_stage_fault_supervisor_pkg

// File: rtl/input_sync.sv
`timescale 1ns/1ns
module input_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : input_sync

// File: test/system_controller_model.sv
`timescale 1ns/1ns
module system_controller_model #(
  parameter int HOLD_CYC = 10
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic fault_low,
  input wire logic ready,
  input wire logic reset_req,
  output logic rst_pin_n,
  output logic audio_on
);
  int gap;
  logic fault_seen;
  // reset release held back until HOLD_CYC cycles after the fault last went low
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gap <= HOLD_CYC;
      fault_seen <= 1'b0;
      rst_pin_n <= 1'b0;
    end else begin
      fault_seen <= fault_low;
      if (fault_low && !fault_seen) begin
        gap <= 0;
      end else if (gap < HOLD_CYC) begin
        gap <= gap + 1;
      end
      // reset only goes low on request; its rising edge waits out the fault gap
      rst_pin_n <= !reset_req && (rst_pin_n || (gap >= HOLD_CYC));
    end
  end
  assign audio_on = ready;
endmodule : system_controller_model

// File: test/power_stage_fault_supervisor_bench.sv
`timescale 1ns/1ns
module power_stage_fault_supervisor_bench;
  localparam int STEP = 20;
  logic sys_clk, rst_pin_n, weak_pulldown, fault_shutdown_n_oe, ready, osc_sync_pins_oe, osc_run;
  logic temp_warn_low_n_oe, temp_warn_high_n_oe, warn2;
  logic [3:0] bridge_enable;
  logic reset_n = 1'b0, reset_req = 1'b1, supply_present = 1'b0, common_supply_low = 1'b0;
  logic temp_over_100 = 1'b0, temp_over_125 = 1'b0, temp_over_155 = 1'b0;
  logic overload_guard = 1'b0, overcurrent_guard = 1'b0, freq_trim_pin = 1'b0;
  logic short_to_gnd = 1'b1, short_to_supply = 1'b0;
  logic [3:0] gate_drive_supply_low = 4'h0, bootstrap_low = 4'h0;
  power_stage_fault_supervisor_pkg::out_cfg_t out_cfg =
    power_stage_fault_supervisor_pkg::bridge_tied_cfg;
  int failures = 0, compares = 0, seed, lvl;

  power_stage_fault_supervisor #(.STEP_CYC(STEP), .THREE_LEVEL(1'b1)) power_stage_fault_supervisor_i (
    .sys_clk, .reset_n, .rst_pin_n, .out_cfg, .supply_present, .gate_drive_supply_low,
    .common_supply_low, .bootstrap_low, .temp_over_100, .temp_over_125, .temp_over_155,
    .overload_guard, .overcurrent_guard, .short_to_gnd, .short_to_supply, .freq_trim_pin,
    .bridge_enable, .weak_pulldown, .fault_shutdown_n_oe, .temp_warn_low_n_oe,
    .temp_warn_high_n_oe, .temp_warn_n_oe(), .ready, .osc_sync_pins_oe, .osc_run);
  // two-level variant, warning output only
  power_stage_fault_supervisor #(.STEP_CYC(STEP), .THREE_LEVEL(1'b0)) two_level_i (
    .sys_clk, .reset_n, .rst_pin_n, .out_cfg, .supply_present, .gate_drive_supply_low,
    .common_supply_low, .bootstrap_low, .temp_over_100, .temp_over_125, .temp_over_155,
    .overload_guard, .overcurrent_guard, .short_to_gnd, .short_to_supply, .freq_trim_pin,
    .bridge_enable(), .weak_pulldown(), .fault_shutdown_n_oe(), .temp_warn_low_n_oe(),
    .temp_warn_high_n_oe(), .temp_warn_n_oe(warn2), .ready(), .osc_sync_pins_oe(),
    .osc_run());
  system_controller_model #(.HOLD_CYC(10)) system_controller_model_i (
    .sys_clk, .reset_n, .fault_low(fault_shutdown_n_oe), .ready, .reset_req, .rst_pin_n,
    .audio_on());

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task chk_vec(input logic [3:0] got, input logic [3:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask : chk_vec

  task chk_bit(input logic got, input logic exp, input string what);
    chk_vec({3'h0, got}, {3'h0, exp}, what);
  endtask : chk_bit

  task wait_run(input int lim);
    int n;
    n = 0;
    while (bridge_enable !== 4'hf && n < lim) begin
      cyc(1);
      n++;
    end
    chk_vec(bridge_enable, 4'hf, "bridges not running");
  endtask : wait_run

  task pin_reset();
    reset_req = 1'b1;
    cyc(4);
  endtask : pin_reset

  function automatic logic [1:0] warn_exp(input int l);
    return {l > 0, l > 1};
  endfunction : warn_exp

  task give_verdict();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    give_verdict();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    seed = 5;
    cyc(8);
    reset_n = 1'b1;
    supply_present = 1'b1;
    cyc(10);
    chk_bit(fault_shutdown_n_oe, 1'b1, "fault during check");
    chk_vec(bridge_enable, 4'h0, "bridges on short");
    reset_req = 1'b0;
    short_to_gnd = 1'b0;
    short_to_supply = 1'b1;
    cyc(40);
    chk_vec(bridge_enable, 4'h0, "supply short step");
    short_to_supply = 1'b0;
    cyc(STEP - 5);
    chk_vec(bridge_enable, 4'h0, "check too short");
    wait_run(60);
    chk_bit(fault_shutdown_n_oe, 1'b0, "fault after check");
    chk_bit(ready, 1'b1, "ready in run");
    short_to_gnd = 1'b1;
    cyc(10);
    chk_vec(bridge_enable, 4'hf, "late short");
    short_to_gnd = 1'b0;
    overcurrent_guard = 1'b1;
    cyc(4);
    chk_bit(ready, 1'b0, "ready on overcurrent");
    overcurrent_guard = 1'b0;
    for (int i = 0; i < 4; i++) begin
      bootstrap_low = 4'($random(seed));
      cyc(4);
      chk_vec(bridge_enable, ~bootstrap_low, "bootstrap");
    end
    bootstrap_low = 4'h0;
    for (int i = 0; i < 8; i++) begin
      lvl = {$random(seed)} % 3;
      temp_over_100 = lvl > 0;
      temp_over_125 = lvl > 1;
      cyc(4);
      chk_vec({2'h0, temp_warn_low_n_oe, temp_warn_high_n_oe}, {2'h0, warn_exp(lvl)}, "warn");
      chk_bit(warn2, lvl > 1, "warn two-level");
    end
    {temp_over_100, temp_over_125} = 2'h0;
    for (int i = 0; i < 5; i++) begin
      gate_drive_supply_low = (i < 4) ? 4'h1 << i : 4'h0;
      common_supply_low = i == 4;
      cyc(4);
      chk_vec(bridge_enable, 4'h0, "undervoltage");
      chk_bit(fault_shutdown_n_oe, 1'b1, "undervoltage fault");
      gate_drive_supply_low = 4'h0;
      common_supply_low = 1'b0;
      cyc(4);
      chk_vec(bridge_enable, 4'hf, "undervoltage recovery");
    end
    temp_over_155 = 1'b1;
    cyc(4);
    chk_bit(fault_shutdown_n_oe, 1'b1, "thermal fault");
    temp_over_155 = 1'b0;
    cyc(10);
    chk_vec(bridge_enable, 4'h0, "thermal latch");
    pin_reset();
    chk_bit(fault_shutdown_n_oe, 1'b0, "fault hidden in reset");
    chk_vec(bridge_enable, 4'h0, "bridges in reset");
    chk_bit(weak_pulldown, 1'b1, "pulldown in reset");
    reset_req = 1'b0;
    wait_run(15);
    overload_guard = 1'b1;
    cyc(4);
    overload_guard = 1'b0;
    cyc(10);
    chk_bit(fault_shutdown_n_oe, 1'b1, "overload latch");
    pin_reset();
    reset_req = 1'b0;
    wait_run(15);
    chk_bit(osc_run, 1'b1, "master oscillator");
    freq_trim_pin = 1'b1;
    cyc(4);
    chk_vec({2'h0, osc_run, osc_sync_pins_oe}, 4'h0, "slave oscillator");
    overload_guard = 1'b1;
    cyc(4);
    reset_n = 1'b0;
    overload_guard = 1'b0;
    out_cfg = power_stage_fault_supervisor_pkg::single_ended_cfg;
    cyc(2);
    reset_n = 1'b1;
    wait_run(10);
    chk_bit(fault_shutdown_n_oe, 1'b0, "power-on clear");
    pin_reset();
    chk_bit(weak_pulldown, 1'b0, "no pulldown single-ended");
    give_verdict();
  end
endmodule : power_stage_fault_supervisor_bench
